// >>> src/iff_top.sv
// Filtered measurement path feeding the frame buffer with byte counts.
//
// Function
// - Filtered value is (old times coefficient plus raw) over coefficient plus one.
// - A coefficient write resets the filter; the next raw value passes and seeds.
// - Filter resets when a measurement enable falls or sleep goes to normal.
// - After a measurement is enabled its first value passes unfiltered and seeds.
// - The frame buffer holds at most 511 bytes in its 512-byte memory.
// - Writing needs buffer enable and at least one channel store bit.
// - With writing off, stored frames stay readable but no frames are added.
// - Pressure and temperature storing are selected independently.
// - Source select 01 stores filtered data, any other value raw data.
// - Byte count splits: high bit 0 holds the MSB, low holds bits 7 to 0.
// - Byte count rises only once a whole frame is written.
// - Byte count falls each time a whole frame is read out.
// - Byte count moves only by whole frame lengths.
// - Buffer input is down-sampled by two to the sub-sampling field.
// - Down-sampling only in normal mode, aligned to the measurement grid.
// - Sleep to normal resets the down-sampling counter; first result is stored.
// - Mode field: 00 sleep, 01 or 10 forced, 11 normal.
// - Normal mode alternates measurement and standby at the output data rate.
`timescale 1ns/100ps
`default_nettype none
module iff_top
  import iff_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Configuration
  input  wire iff_cfg_s   cfg,
  input  wire logic       iir_wr,
  // Conversion results
  input  wire iff_meas_s  meas,
  // Buffer read side
  input  wire logic       rd_req,
  output logic [7:0]      rd_data,
  output logic            rd_valid,
  // Byte count
  output logic [7:0]      count_low,
  output logic [7:0]      count_high
);

  function automatic logic mode_normal(input logic [1:0] m);
    mode_normal = (m == MODE_NORMAL);
  endfunction

  // ************************************************************
  // Configuration tracking and filters
  // ************************************************************
  logic [1:0]        mode_prev, next_mode_prev;
  logic [N_CH-1:0]   en_prev, next_en_prev;
  logic [N_CH-1:0]   ch_en, clr, busy;
  logic              s2n;
  logic [DATA_W-1:0] raw  [N_CH];
  logic [DATA_W-1:0] filt [N_CH];
  assign ch_en[CH_PRESS] = cfg.press_en;
  assign ch_en[CH_TEMP]  = cfg.temp_en;
  assign raw[CH_PRESS]   = meas.press;
  assign raw[CH_TEMP]    = meas.temp;
  assign s2n = (mode_prev == MODE_SLEEP) && mode_normal(cfg.mode);

  always_comb begin
    next_mode_prev = cfg.mode;
    next_en_prev   = ch_en;
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode_prev <= MODE_SLEEP;
      en_prev   <= '0;
    end else begin
      mode_prev <= next_mode_prev;
      en_prev   <= next_en_prev;
    end
  end

  for (genvar i = 0; i < N_CH; i++) begin : g_ch
    assign clr[i] = iir_wr || (en_prev[i] != ch_en[i]) || s2n;
    iff_iir u_iir (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .iir_sel  (cfg.iir_sel),
      .clear    (clr[i]),
      .in_valid (meas.valid && ch_en[i]),
      .in_data  (raw[i]),
      .busy     (busy[i]),
      .out_data (filt[i])
    );
  end

  // ************************************************************
  // Down-sampling
  // ************************************************************
  // The counter steps on every normal-mode measurement, even with the
  // buffer off, so stored samples stay on the measurement grid.
  logic [SS_W-1:0] ss_cnt, next_ss_cnt;
  logic [SS_W-1:0] ss_mask;
  logic            ss_hit;
  assign ss_mask = SS_W'((8'h01 << cfg.subsamp) - 8'h01);
  assign ss_hit  = !mode_normal(cfg.mode) || ((ss_cnt & ss_mask) == '0);

  always_comb begin
    next_ss_cnt = ss_cnt;
    if (s2n) begin
      next_ss_cnt = '0;
    end else if (meas.valid && mode_normal(cfg.mode)) begin
      next_ss_cnt = ss_cnt + SS_W'(1);
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ss_cnt <= '0;
    end else begin
      ss_cnt <= next_ss_cnt;
    end
  end

  // ************************************************************
  // Frame writer
  // ************************************************************
  logic [7:0]        mem [BUF_BYTES];
  iff_wr_e           wr_state, next_wr_state;
  logic              wr_t, wr_p, next_wr_t, next_wr_p;
  logic [2:0]        wr_idx, next_wr_idx;
  logic [3:0]        wr_len, next_wr_len;
  logic [PTR_W-1:0]  wp, next_wp, rp, next_rp;
  logic [DATA_W-1:0] tdat, pdat, next_tdat, next_pdat;
  logic [DATA_W-1:0] raw_t, raw_p, next_raw_t, next_raw_p;
  logic              write_on, take, room, go_push, wr_commit, mem_we;
  logic [7:0]        mem_wdata;
  logic [47:0]       stream;
  logic [3:0]        len_new;
  logic [CNT_W-1:0]  cnt, next_cnt;
  assign write_on = cfg.buf_en && (cfg.buf_press || cfg.buf_temp);
  // no new frames while writing is off
  assign take = meas.valid && write_on && ss_hit && (wr_state == WR_IDLE)
             && ((cfg.buf_temp && cfg.temp_en)
             || (cfg.buf_press && cfg.press_en));
  assign len_new = iff_frame_len(wr_t, wr_p);
  assign room    = ({1'b0, cnt} + 10'(len_new)) <= {1'b0, CNT_MAX};
  assign go_push = (wr_state == WR_WAIT) && (busy == '0) && room;
  assign stream  = wr_t ? {pdat, tdat} : {24'h00_0000, pdat};

  always_comb begin
    next_wr_state = wr_state;
    next_wr_t     = wr_t;
    next_wr_p     = wr_p;
    next_wr_idx   = wr_idx;
    next_wr_len   = wr_len;
    next_wp       = wp;
    next_tdat     = tdat;
    next_pdat     = pdat;
    next_raw_t    = raw_t;
    next_raw_p    = raw_p;
    wr_commit     = 1'b0;
    mem_we        = 1'b0;
    mem_wdata     = HDR_SENSOR;
    unique case (wr_state)
      WR_IDLE: begin
        if (take) begin
          next_wr_t     = cfg.buf_temp && cfg.temp_en;
          next_wr_p     = cfg.buf_press && cfg.press_en;
          next_raw_t    = meas.temp;
          next_raw_p    = meas.press;
          next_wr_state = WR_WAIT;
        end
      end
      WR_WAIT: begin
        if (busy == '0) begin
          // A frame that does not fit is dropped whole.
          next_wr_state = room ? WR_PUSH : WR_IDLE;
          next_wr_len   = len_new;
          next_wr_idx   = 3'h0;
          if (cfg.data_sel == SEL_FILTERED) begin
            next_tdat = filt[CH_TEMP];
            next_pdat = filt[CH_PRESS];
          end else begin
            next_tdat = raw_t;
            next_pdat = raw_p;
          end
        end
      end
      WR_PUSH: begin
        mem_we = 1'b1;
        if (wr_idx == 3'h0) begin
          mem_wdata = HDR_SENSOR | (8'(wr_t) << HDR_T_BIT)
                    | (8'(wr_p) << HDR_P_BIT);
        end else begin
          mem_wdata = stream[8*(wr_idx-3'h1) +: 8];
        end
        next_wp     = wp + PTR_W'(1);
        next_wr_idx = wr_idx + 3'h1;
        if (4'(wr_idx) == wr_len - 4'h1) begin
          wr_commit     = 1'b1;
          next_wr_state = WR_IDLE;
        end
      end
      default: begin
        next_wr_state = WR_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_state <= WR_IDLE;
      wr_t     <= 1'b0;
      wr_p     <= 1'b0;
      wr_idx   <= 3'h0;
      wr_len   <= 4'h0;
      wp       <= '0;
      tdat     <= '0;
      pdat     <= '0;
      raw_t    <= '0;
      raw_p    <= '0;
    end else begin
      wr_state <= next_wr_state;
      wr_t     <= next_wr_t;
      wr_p     <= next_wr_p;
      wr_idx   <= next_wr_idx;
      wr_len   <= next_wr_len;
      wp       <= next_wp;
      tdat     <= next_tdat;
      pdat     <= next_pdat;
      raw_t    <= next_raw_t;
      raw_p    <= next_raw_p;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (mem_we) begin
      mem[wp] <= mem_wdata;
    end
  end

  // ************************************************************
  // Reader and byte count
  // ************************************************************
  // The count still holds a partly read frame, so a frame is only freed
  // and its space reused once its last byte has left.
  logic [2:0]       rd_left, next_rd_left;
  logic [3:0]       rd_len, next_rd_len, hdr_len;
  logic [7:0]       next_rd_data;
  logic             emp_ph, next_emp_ph, rd_done;
  assign hdr_len = iff_frame_len(mem[rp][HDR_T_BIT], mem[rp][HDR_P_BIT]);
  always_comb begin
    next_rp      = rp;
    next_rd_left = rd_left;
    next_rd_len  = rd_len;
    next_rd_data = rd_data;
    next_emp_ph  = emp_ph;
    rd_done      = 1'b0;
    if (rd_req) begin
      if (cnt != '0) begin
        next_rd_data = mem[rp];
        next_rp      = rp + PTR_W'(1);
        next_emp_ph  = 1'b0;
        if (rd_left == 3'h0) begin
          next_rd_len  = hdr_len;
          next_rd_left = 3'(hdr_len - 4'h1);
        end else begin
          next_rd_left = rd_left - 3'h1;
          rd_done      = (rd_left == 3'h1);
        end
      end else begin
        next_rd_data = emp_ph ? EMPTY_DATA : EMPTY_HDR;
        next_emp_ph  = !emp_ph;
      end
    end
    next_cnt = cnt + (wr_commit ? CNT_W'(wr_len) : '0)
                   - (rd_done ? CNT_W'(rd_len) : '0);
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rp       <= '0;
      rd_left  <= 3'h0;
      rd_len   <= 4'h0;
      rd_data  <= 8'h00;
      rd_valid <= 1'b0;
      emp_ph   <= 1'b0;
      cnt      <= '0;
    end else begin
      rp       <= next_rp;
      rd_left  <= next_rd_left;
      rd_len   <= next_rd_len;
      rd_data  <= next_rd_data;
      rd_valid <= rd_req;
      emp_ph   <= next_emp_ph;
      cnt      <= next_cnt;
    end
  end

  assign count_low  = cnt[7:0];
  assign count_high = {7'h00, cnt[CNT_W-1]};

  // ************************************************************
  // Checks
  // ************************************************************
  property p_cnt_frames;
    @(posedge clk_sys) disable iff (rst)
    cnt != $past(cnt) |-> $past(wr_commit) || $past(rd_done);
  endproperty
  a_cnt_frames: assert property (p_cnt_frames)
    else $error("byte count moved without a whole frame");
  property p_commit_up;
    @(posedge clk_sys) disable iff (rst)
    wr_commit && !rd_done |=> cnt == $past(cnt) + CNT_W'($past(wr_len));
  endproperty
  a_commit_up: assert property (p_commit_up)
    else $error("byte count not raised by frame length");
  property p_read_down;
    @(posedge clk_sys) disable iff (rst)
    rd_done && !wr_commit |=> cnt == $past(cnt) - CNT_W'($past(rd_len));
  endproperty
  a_read_down: assert property (p_read_down)
    else $error("byte count not lowered after frame read");
  property p_gate_off;
    @(posedge clk_sys) disable iff (rst)
    wr_state == WR_IDLE && !write_on |=> wr_state == WR_IDLE;
  endproperty
  a_gate_off: assert property (p_gate_off)
    else $error("frame started while writing disabled");
  property p_ss_skip;
    @(posedge clk_sys) disable iff (rst)
    meas.valid && mode_normal(cfg.mode) && (ss_cnt & ss_mask) != '0
      && wr_state == WR_IDLE |=> wr_state == WR_IDLE;
  endproperty
  a_ss_skip: assert property (p_ss_skip)
    else $error("down-sampled measurement was stored");
  property p_ss_restart;
    @(posedge clk_sys) disable iff (rst)
    s2n |=> ss_cnt == '0 && ss_hit;
  endproperty
  a_ss_restart: assert property (p_ss_restart)
    else $error("down-sampling counter not restarted");
  property p_sel_filt;
    @(posedge clk_sys) disable iff (rst)
    go_push && cfg.data_sel == SEL_FILTERED
      |=> tdat == $past(filt[CH_TEMP]) && pdat == $past(filt[CH_PRESS]);
  endproperty
  a_sel_filt: assert property (p_sel_filt)
    else $error("filtered data not selected for buffer");
  property p_rd_adv;
    @(posedge clk_sys) disable iff (rst)
    rd_req && cnt != '0 |=> rp == $past(rp) + PTR_W'(1) && rd_valid;
  endproperty
  a_rd_adv: assert property (p_rd_adv)
    else $error("read of stored byte did not advance");

endmodule
`default_nettype wire

// >>> src/iff_pkg.sv
// Constants, carrier types and shared helpers of the filtered buffer input path.
package iff_pkg;

  // ************************************************************
  // Widths and sizes
  // ************************************************************
  localparam int unsigned DATA_W    = 24;
  localparam int unsigned BUF_BYTES = 512;
  localparam int unsigned PTR_W     = 9;
  localparam int unsigned CNT_W     = 9;
  localparam int unsigned SS_W      = 7;
  localparam int unsigned N_CH      = 2;
  localparam int unsigned CH_PRESS  = 0;
  localparam int unsigned CH_TEMP   = 1;
  localparam logic [8:0]  CNT_MAX   = 9'h1ff;

  // ************************************************************
  // Field encodings
  // ************************************************************
  localparam logic [1:0] MODE_SLEEP   = 2'h0;
  localparam logic [1:0] MODE_NORMAL  = 2'h3;
  localparam logic [1:0] SEL_FILTERED = 2'h1;
  localparam logic [2:0] IIR_OFF      = 3'h0;

  // ************************************************************
  // Frame layout
  // ************************************************************
  localparam logic [7:0]  HDR_SENSOR = 8'h80;
  localparam logic [7:0]  EMPTY_HDR  = 8'h80;
  localparam logic [7:0]  EMPTY_DATA = 8'h00;
  localparam int unsigned HDR_T_BIT  = 4;
  localparam int unsigned HDR_P_BIT  = 2;
  localparam logic [3:0]  HDR_BYTES  = 4'h1;
  localparam logic [3:0]  CH_BYTES   = 4'h3;

  // ************************************************************
  // Divider timing
  // ************************************************************
  localparam int unsigned DIV_STEPS = 32;
  localparam logic [5:0]  DIV_LAST  = 6'h1f;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_WAIT = 2'b01,
    WR_PUSH = 2'b10
  } iff_wr_e;

  typedef struct packed {
    logic [1:0] mode;
    logic       press_en;
    logic       temp_en;
    logic [2:0] iir_sel;
    logic       buf_en;
    logic       buf_press;
    logic       buf_temp;
    logic [1:0] data_sel;
    logic [2:0] subsamp;
  } iff_cfg_s;

  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] press;
    logic [DATA_W-1:0] temp;
  } iff_meas_s;

  function automatic logic [3:0] iff_frame_len(input logic t,
                                               input logic p);
    iff_frame_len = HDR_BYTES + (t ? CH_BYTES : 4'h0)
                  + (p ? CH_BYTES : 4'h0);
  endfunction

endpackage

// >>> src/iff_iir.sv
// Recursive smoothing filter for one measurement channel.
`timescale 1ns/100ps
`default_nettype none
module iff_iir
  import iff_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // Control
  input  wire logic [2:0]        iir_sel,
  input  wire logic              clear,
  // Sample in
  input  wire logic              in_valid,
  input  wire logic [DATA_W-1:0] in_data,
  // Result
  output logic                   busy,
  output logic [DATA_W-1:0]      out_data
);

  logic              primed, next_primed;
  logic              next_busy;
  logic [5:0]        step, next_step;
  logic [31:0]       num, next_num;
  logic [7:0]        rem, next_rem;
  logic [8:0]        div, next_div;
  logic [DATA_W-1:0] next_out;
  logic [8:0]        trial;
  logic              ge;
  logic [31:0]       numer;

  // ************************************************************
  // Next state
  // ************************************************************
  // The divisor is latched at start so a coefficient write during a
  // division cannot corrupt it; the write also aborts the division.
  always_comb begin
    next_primed = primed;
    next_busy   = busy;
    next_step   = step;
    next_num    = num;
    next_rem    = rem;
    next_div    = div;
    next_out    = out_data;
    trial       = {rem, num[31]};
    ge          = (trial >= div);
    numer = (32'(out_data) << iir_sel) + 32'(in_data);
    if (clear) begin
      next_busy   = 1'b0;
      next_primed = 1'b0;
    end
    if (busy && !clear) begin
      next_num  = {num[30:0], ge};
      next_rem  = ge ? 8'(trial - div) : trial[7:0];
      next_step = step + 6'h1;
      if (step == DIV_LAST) begin
        next_busy   = 1'b0;
        next_out    = next_num[DATA_W-1:0];
        next_primed = 1'b1;
      end
    end else if (in_valid) begin
      if (!next_primed || iir_sel == IIR_OFF) begin
        next_out    = in_data;
        next_primed = 1'b1;
      end else begin
        next_num  = numer;
        next_rem  = 8'h00;
        next_step = 6'h00;
        next_div  = (9'h001 << iir_sel) + 9'h001;
        next_busy = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      primed   <= 1'b0;
      busy     <= 1'b0;
      step     <= 6'h00;
      num      <= 32'h0000_0000;
      rem      <= 8'h00;
      div      <= 9'h001;
      out_data <= '0;
    end else begin
      primed   <= next_primed;
      busy     <= next_busy;
      step     <= next_step;
      num      <= next_num;
      rem      <= next_rem;
      div      <= next_div;
      out_data <= next_out;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  property p_pass_first;
    @(posedge clk_sys) disable iff (rst)
    in_valid && !busy && (clear || !primed)
      |=> out_data == $past(in_data);
  endproperty
  a_pass_first: assert property (p_pass_first)
    else $error("first sample after clear not passed through");

  property p_off_pass;
    @(posedge clk_sys) disable iff (rst)
    in_valid && !busy && !clear && iir_sel == IIR_OFF
      |=> out_data == $past(in_data) && !busy;
  endproperty
  a_off_pass: assert property (p_off_pass)
    else $error("filter off did not pass raw value");

  // Consecutive busy cycles are counted here, so that the division length
  // can be checked without unrolling a long repetition.
  logic [5:0] busy_run, next_busy_run;

  always_comb begin
    next_busy_run = busy ? busy_run + 6'h01 : 6'h00;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busy_run <= 6'h00;
    end else begin
      busy_run <= next_busy_run;
    end
  end

  property p_div_time;
    @(posedge clk_sys) disable iff (rst)
    $fell(busy) && !$past(clear) |-> busy_run == 6'(DIV_STEPS) && primed;
  endproperty
  a_div_time: assert property (p_div_time)
    else $error("filter result not ready after division steps");

  property p_div_bound;
    @(posedge clk_sys) disable iff (rst)
    busy |-> busy_run < 6'(DIV_STEPS);
  endproperty
  a_div_bound: assert property (p_div_bound)
    else $error("filter division ran too long");

endmodule
`default_nettype wire

// >>> bench/iff_host.sv
// Host reader model that pulls buffer bytes one at a time.
`timescale 1ns/100ps
`default_nettype none
module iff_host (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Bench command
  input  wire logic       start,
  input  wire logic [3:0] n_bytes,
  input  wire logic [3:0] gap,
  output logic            done,
  output logic [7:0]      got [0:15],
  // Buffer read side
  output logic            rd_req,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid
);
  // A gap between reads models a slow host; zero reads every cycle.
  initial begin
    rd_req = 1'b0;
    done   = 1'b0;
    forever begin
      @(posedge clk_sys);
      if (start === 1'b1 && rst === 1'b0) begin
        done = 1'b0;
        @(negedge clk_sys);
        for (int i = 0; i < int'(n_bytes); i++) begin
          rd_req = 1'b1;
          @(negedge clk_sys);
          got[i] = rd_valid ? rd_data : 8'hxx;
          if (gap != 4'h0) begin
            rd_req = 1'b0;
            repeat (gap) @(negedge clk_sys);
          end
        end
        rd_req = 1'b0;
        done   = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> bench/testbench.sv
// Self-checking bench for the filtered buffer input path.
`timescale 1ns/100ps
`default_nettype none
module testbench
  import iff_pkg::*;
;
  logic       clk_sys = 1'b0;
  logic       rst     = 1'b1;
  iff_cfg_s   cfg;
  logic       iir_wr  = 1'b0;
  iff_meas_s  meas;
  logic       rd_req;
  logic [7:0] rd_data;
  logic       rd_valid;
  logic [7:0] count_low;
  logic [7:0] count_high;
  logic       start   = 1'b0;
  logic [3:0] n_bytes = 4'h0;
  logic [3:0] gap     = 4'h0;
  logic       done;
  logic [7:0] got [0:15];
  int         failures = 0;
  int         n_tests  = 0;

  always #20 clk_sys = ~clk_sys;

  iff_top dut (.clk_sys(clk_sys), .rst(rst), .cfg(cfg), .iir_wr(iir_wr),
    .meas(meas), .rd_req(rd_req), .rd_data(rd_data), .rd_valid(rd_valid),
    .count_low(count_low), .count_high(count_high));

  iff_host host (.clk_sys(clk_sys), .rst(rst), .start(start),
    .n_bytes(n_bytes), .gap(gap), .done(done), .got(got), .rd_req(rd_req),
    .rd_data(rd_data), .rd_valid(rd_valid));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    if (failures == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic cnt_is(input logic [8:0] n);
    check({8'h0, count_high, count_low}, {15'h0, n});
  endtask

  task automatic measure(input logic [23:0] p, input logic [23:0] t,
                         input int w);
    @(negedge clk_sys);
    meas = '{1'b1, p, t};
    @(negedge clk_sys);
    meas.valid = 1'b0;
    repeat (w) @(negedge clk_sys);
  endtask

  task automatic read(input logic [3:0] n, input logic [3:0] g);
    int i;
    @(negedge clk_sys);
    n_bytes = n;
    gap = g;
    start = 1'b1;
    @(negedge clk_sys);
    start = 1'b0;
    i = 0;
    while (done !== 1'b1) begin
      @(negedge clk_sys);
      i++;
      if (i > 300) begin
        check(24'h1, 24'h0);
        end_sim();
      end
    end
    @(negedge clk_sys);
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_frame();
    cfg.temp_en = 1'b1;
    measure(24'h0a0b0c, 24'h123456, 3);
    cnt_is(9'h0);
    repeat (40) @(negedge clk_sys);
    cnt_is(9'h4);
    read(4'h4, 4'h2);
    check({16'h0, got[0]}, 24'h90);
    check({got[3], got[2], got[1]}, 24'h123456);
    cnt_is(9'h0);
    cfg.press_en = 1'b1;
    measure(24'h0a0b0c, 24'h1, 45);
    cnt_is(9'h7);
    read(4'h7, 4'h0);
    check({16'h0, got[0]}, 24'h94);
    check({got[6], got[5], got[4]}, 24'h0a0b0c);
  endtask

  task automatic t_fill();
    for (int i = 0; i < 74; i++) begin
      measure(24'h0, i[23:0], 45);
      if (i == 36) begin
        cnt_is(9'h103);
      end
    end
    cnt_is(9'h1ff);
    for (int i = 0; i < 73; i++) begin
      read(4'h7, 4'h0);
      check({got[3], got[2], got[1]}, i[23:0]);
    end
    cnt_is(9'h0);
  endtask

  task automatic t_gate();
    cfg.buf_temp = 1'b0;
    measure(24'h00abcd, 24'h0, 45);
    cfg.buf_en = 1'b0;
    measure(24'h1, 24'h1, 45);
    cnt_is(9'h4);
    read(4'h4, 4'h0);
    check({16'h0, got[0]}, 24'h84);
    check({got[3], got[2], got[1]}, 24'h00abcd);
    cfg.buf_en = 1'b1;
    cfg.buf_press = 1'b0;
    measure(24'h1, 24'h1, 45);
    cnt_is(9'h0);
    cfg.buf_temp = 1'b1;
  endtask

  task automatic t_filter();
    logic [23:0] e;
    for (int k = 0; k < 8; k++) begin
      cfg.iir_sel = k[2:0];
      cfg.data_sel = 2'h1;
      @(negedge clk_sys);
      iir_wr = 1'b1;
      @(negedge clk_sys);
      iir_wr = 1'b0;
      measure(24'h0, 24'h001000, 45);
      measure(24'h0, 24'h0, 45);
      cfg.data_sel = 2'h2;
      measure(24'h0, 24'h5, 45);
      read(4'hc, 4'h0);
      e = (k == 0) ? 24'h0 : (24'h1000 << k) / ((24'h1 << k) + 24'h1);
      check({got[3], got[2], got[1]}, 24'h001000);
      check({got[7], got[6], got[5]}, e);
      check({got[11], got[10], got[9]}, 24'h5);
    end
  endtask

  // Filter still holds coefficient 128 state; the mode change must clear it.
  task automatic t_normal();
    cfg.data_sel = 2'h1;
    cfg.mode = MODE_SLEEP;
    repeat (3) @(negedge clk_sys);
    cfg.mode = MODE_NORMAL;
    measure(24'h0, 24'h300, 45);
    repeat (3) measure(24'h0, 24'h0, 45);
    cnt_is(9'h8);
    read(4'h8, 4'h1);
    check({got[3], got[2], got[1]}, 24'h300);
    check({got[7], got[6], got[5]}, 24'h2f4);
    read(4'h2, 4'h0);
    check({8'h0, got[1], got[0]}, 24'h80);
    // The counter is even here, so this one is stored and leaves it odd; only a restart stores the next one.
    measure(24'h0, 24'h10, 45);
    cfg.mode = MODE_SLEEP;
    repeat (3) @(negedge clk_sys);
    cfg.mode = MODE_NORMAL;
    measure(24'h0, 24'h20, 45);
    cnt_is(9'h8);
    read(4'h8, 4'h0);
    check({got[7], got[6], got[5]}, 24'h20);
  endtask

  initial begin
    cfg = '{2'h1, 1'b0, 1'b0, 3'h0, 1'b1, 1'b1, 1'b1, 2'h0, 3'h1};
    meas = '0;
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    t_frame();
    t_fill();
    t_gate();
    t_filter();
    t_normal();
    end_sim();
  end
endmodule
`default_nettype wire
